// ### pin_irq_pkg.sv
// constants and types shared by the external pin interrupt unit
package pin_irq_pkg;

    // ------------------------------------------------------------
    // register bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int PIN_COUNT = 8;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ASYNC_SENSE_OFS = 3'h0;
    localparam logic [ADDR_W-1:0] SYNC_SENSE_OFS = 3'h1;
    localparam logic [ADDR_W-1:0] MASK_OFS = 3'h2;
    localparam logic [ADDR_W-1:0] FLAGS_OFS = 3'h3;
    localparam logic [ADDR_W-1:0] PIN_STATE_OFS = 3'h4;

    // ------------------------------------------------------------
    // reset values and the unmapped read value
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] ASYNC_SENSE_RST = 8'h00;
    localparam logic [DATA_W-1:0] SYNC_SENSE_RST = 8'h00;
    localparam logic [DATA_W-1:0] MASK_RST = 8'h00;
    localparam logic [DATA_W-1:0] FLAGS_RST = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // sense selection per input, two bits each
    // ------------------------------------------------------------
    localparam int SENSE_W = 2;
    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_CHANGE = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_t;

endpackage

// ### external_pin_interrupt_unit.sv
// eight-input external pin interrupt unit with register port
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module external_pin_interrupt_unit #(
    parameter int ASYNC_COUNT = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [pin_irq_pkg::PIN_COUNT-1:0] externalRequestPins,
    input wire logic globalEnable,
    input wire logic sleepActive,
    input wire logic vectorAck,
    input wire logic [2:0] ackIndex,
    input wire logic [pin_irq_pkg::ADDR_W-1:0] regAddr,
    input wire logic [pin_irq_pkg::DATA_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [pin_irq_pkg::DATA_W-1:0] regRdData,
    output logic [pin_irq_pkg::PIN_COUNT-1:0] requestVector,
    output logic [2:0] vectorIndex,
    output logic irq,
    output logic wakeRequest
);
    import pin_irq_pkg::*;

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    if (ASYNC_COUNT < 1 || ASYNC_COUNT > PIN_COUNT - 1) begin : g_chk
        $error("ASYNC_COUNT must lie between 1 and 7");
    end

    localparam logic [PIN_COUNT-1:0] ASYNC_SEL =
        PIN_COUNT'((1 << ASYNC_COUNT) - 1);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [DATA_W-1:0] asyncSense_q;
    logic [DATA_W-1:0] syncSense_q;
    logic [DATA_W-1:0] mask_q;
    logic [DATA_W-1:0] flags_q;
    logic [DATA_W-1:0] flags_d;
    logic [PIN_COUNT-1:0] bufferOff_q;
    logic [PIN_COUNT-1:0] pinSeen;
    logic [PIN_COUNT-1:0] syncA_q;
    logic [PIN_COUNT-1:0] syncB_q;
    logic [PIN_COUNT-1:0] syncC_q;
    logic [PIN_COUNT-1:0] edgeEvent;
    logic [PIN_COUNT-1:0] levelMode;
    logic [PIN_COUNT-1:0] levelReq;
    logic [PIN_COUNT-1:0] setVec;
    logic [PIN_COUNT-1:0] clrVec;
    logic [PIN_COUNT-1:0] ackVec;
    logic [PIN_COUNT-1:0] w1cVec;
    logic [2*PIN_COUNT-1:0] senseAll;
    logic [DATA_W-1:0] rdData_d;
    logic wrFlags;

    assign senseAll = {syncSense_q, asyncSense_q};

    // ------------------------------------------------------------
    // sense decode
    // ------------------------------------------------------------
    function automatic logic senseHit(input sense_t mode,
                                      input logic rise,
                                      input logic fall);
        logic hit;
        hit = 1'b0;
        case (mode)
            SENSE_CHANGE: hit = rise | fall;
            SENSE_FALL: hit = fall;
            SENSE_RISE: hit = rise;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction

    // ------------------------------------------------------------
    // pin sampling for level sense and synchronous edges
    // ------------------------------------------------------------
    // first stage is read only by the second
    always_ff @(posedge mclk) begin
        if (rst) begin
            syncA_q <= '0;
            syncB_q <= '0;
            syncC_q <= '0;
        end else begin
            syncA_q <= pinSeen;
            syncB_q <= syncA_q;
            syncC_q <= syncB_q;
        end
    end

    // ------------------------------------------------------------
    // per-input detection
    // ------------------------------------------------------------
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
        sense_t mode;
        logic rise;
        logic fall;

        assign mode = sense_t'(senseAll[SENSE_W*i +: SENSE_W]);
        assign levelMode[i] = (mode == SENSE_LOW);
        // two lows in a row before a level counts
        assign levelReq[i] = levelMode[i] & ~syncB_q[i]
                             & ~syncC_q[i];
        assign edgeEvent[i] = senseHit(mode, rise, fall);

        if (i < ASYNC_COUNT) begin : g_async
            logic riseTgl_q;
            logic fallTgl_q;
            logic [2:0] riseSync_q;
            logic [2:0] fallSync_q;

            // masked inputs lose their buffer during sleep
            assign pinSeen[i] = externalRequestPins[i]
                                & ~bufferOff_q[i];

            // clockless capture: the pin itself clocks a toggle
            always_ff @(posedge pinSeen[i] or posedge rst) begin
                if (rst) begin
                    riseTgl_q <= 1'b0;
                end else begin
                    riseTgl_q <= ~riseTgl_q;
                end
            end

            always_ff @(negedge pinSeen[i] or posedge rst) begin
                if (rst) begin
                    fallTgl_q <= 1'b0;
                end else begin
                    fallTgl_q <= ~fallTgl_q;
                end
            end

            // toggles cross into mclk through two flops
            always_ff @(posedge mclk) begin
                if (rst) begin
                    riseSync_q <= '0;
                    fallSync_q <= '0;
                end else begin
                    riseSync_q <= {riseSync_q[1:0], riseTgl_q};
                    fallSync_q <= {fallSync_q[1:0], fallTgl_q};
                end
            end

            assign rise = riseSync_q[2] ^ riseSync_q[1];
            assign fall = fallSync_q[2] ^ fallSync_q[1];
        end else begin : g_sync
            assign pinSeen[i] = externalRequestPins[i];
            // compare the two newest synchronised samples
            assign rise = syncB_q[i] & ~syncC_q[i];
            assign fall = ~syncB_q[i] & syncC_q[i];
        end
    end

    // ------------------------------------------------------------
    // sleep buffer gating for the asynchronous inputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            bufferOff_q <= '0;
        end else begin
            bufferOff_q <= {PIN_COUNT{sleepActive}} & ~mask_q
                           & ASYNC_SEL;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // sense changes are not guarded; an enabled input may fire
    always_ff @(posedge mclk) begin
        if (rst) begin
            asyncSense_q <= ASYNC_SENSE_RST;
            syncSense_q <= SYNC_SENSE_RST;
            mask_q <= MASK_RST;
        end else if (regWr) begin
            case (regAddr)
                ASYNC_SENSE_OFS: asyncSense_q <= regWrData;
                SYNC_SENSE_OFS: syncSense_q <= regWrData;
                MASK_OFS: mask_q <= regWrData;
                default: mask_q <= mask_q;
            endcase
        end
    end

    // ------------------------------------------------------------
    // flags: set wins over every clear, level mode holds clear
    // ------------------------------------------------------------
    assign wrFlags = regWr && (regAddr == FLAGS_OFS);
    assign w1cVec = wrFlags ? regWrData : '0;
    assign ackVec = vectorAck ? (PIN_COUNT'(1) << ackIndex) : '0;
    assign clrVec = w1cVec | ackVec;
    assign setVec = edgeEvent & ~levelMode;

    always_comb begin
        flags_d = ((flags_q & ~clrVec) | setVec) & ~levelMode;
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_q <= FLAGS_RST;
        end else begin
            flags_q <= flags_d;
        end
    end

    // ------------------------------------------------------------
    // request to the cpu
    // ------------------------------------------------------------
    assign requestVector = (flags_q | levelReq) & mask_q
                           & {PIN_COUNT{globalEnable}};
    assign irq = |requestVector;

    // lowest numbered pending input wins the vector
    always_comb begin
        vectorIndex = 3'h0;
        for (int k = PIN_COUNT - 1; k >= 0; k--) begin
            if (requestVector[k]) begin
                vectorIndex = 3'(k);
            end
        end
    end

    // only levels and asynchronous edges can wake without mclk
    assign wakeRequest = |(mask_q & (levelReq
                           | (flags_q & ASYNC_SEL)));

    // ------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        case (regAddr)
            ASYNC_SENSE_OFS: rdData_d = asyncSense_q;
            SYNC_SENSE_OFS: rdData_d = syncSense_q;
            MASK_OFS: rdData_d = mask_q;
            FLAGS_OFS: rdData_d = flags_q;
            PIN_STATE_OFS: rdData_d = syncB_q;
            default: rdData_d = UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= rdData_d;
        end else begin
            regRdData <= '0;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence syncRiseSeen;
        $rose(syncB_q[PIN_COUNT-1])
            && senseAll[2*PIN_COUNT-1 -: 2] == SENSE_RISE;
    endsequence

    sequence syncFallSeen;
        $fell(syncB_q[PIN_COUNT-1])
            && senseAll[2*PIN_COUNT-1 -: 2] == SENSE_FALL;
    endsequence

    sequence asyncRiseSeen;
        g_pin[0].g_async.riseSync_q[2] != g_pin[0].g_async.riseSync_q[1]
            && asyncSense_q[1:0] == SENSE_RISE;
    endsequence

    AST_SYNC_RISE_FLAG: assert property (
        syncRiseSeen |=> flags_q[PIN_COUNT-1])
        else $error("synchronous rise did not set its flag");

    AST_SYNC_FALL_FLAG: assert property (
        syncFallSeen |=> flags_q[PIN_COUNT-1])
        else $error("synchronous fall did not set its flag");

    AST_ASYNC_RISE_FLAG: assert property (
        asyncRiseSeen |=> flags_q[0])
        else $error("asynchronous rise did not set its flag");

    AST_LEVEL_FLAG_CLEAR: assert property (
        (flags_q & $past(levelMode)) == '0)
        else $error("flag set while input senses low level");

    AST_GLOBAL_GATE: assert property (
        !globalEnable |-> !irq && requestVector == '0)
        else $error("request raised with global enable low");

    AST_LEVEL_HOLD: assert property (
        (levelReq & mask_q & {PIN_COUNT{globalEnable}}
            & ~requestVector) == '0)
        else $error("held low level lost its request");

    AST_W1C_CLEAR: assert property (
        wrFlags |=> (flags_q & $past(regWrData & ~setVec)) == '0)
        else $error("written one did not clear the flag");

    AST_SET_WINS: assert property (
        setVec != '0 |=> (flags_q & $past(setVec)) == $past(setVec))
        else $error("event lost against a clear");

    AST_VECTOR_PICK: assert property (
        irq |-> requestVector[vectorIndex]
            && (requestVector & ((PIN_COUNT'(1) << vectorIndex)
                - PIN_COUNT'(1))) == '0)
        else $error("vector does not name the lowest request");

    AST_READ_SLOT: assert property (
        regRd && regAddr == MASK_OFS && !regWr
            |=> regRdData == $past(mask_q) ##1 regRd || regRdData == '0)
        else $error("read data misplaced in time");

    sequence asyncFallSeen;
        g_pin[0].g_async.fallSync_q[2] != g_pin[0].g_async.fallSync_q[1]
            && asyncSense_q[1:0] == SENSE_FALL;
    endsequence

    sequence syncChangeSeen;
        $changed(syncB_q[PIN_COUNT-1])
            && senseAll[2*PIN_COUNT-1 -: 2] == SENSE_CHANGE;
    endsequence

    sequence levelLowTwice;
        levelMode[PIN_COUNT-2] && !syncB_q[PIN_COUNT-2]
            ##1 levelMode[PIN_COUNT-2] && !syncB_q[PIN_COUNT-2];
    endsequence

    AST_ASYNC_FALL_FLAG: assert property (
        asyncFallSeen |=> flags_q[0])
        else $error("asynchronous fall did not set its flag");

    AST_SYNC_CHANGE_FLAG: assert property (
        syncChangeSeen |=> flags_q[PIN_COUNT-1])
        else $error("synchronous change did not set its flag");

    AST_ACK_CLEAR: assert property (
        vectorAck |=> (flags_q & $past(ackVec & ~setVec)) == '0)
        else $error("entered vector did not clear its flag");

    AST_LEVEL_TWO_SAMPLES: assert property (
        levelLowTwice |-> levelReq[PIN_COUNT-2])
        else $error("two low samples raised no level request");

    AST_SLEEP_GATE: assert property (
        sleepActive |=> (pinSeen & ASYNC_SEL & ~$past(mask_q)) == '0)
        else $error("masked input kept its buffer during sleep");

endmodule

`default_nettype wire

// ### pin_board_model.sv
// board-level driver model for the external request pins
`timescale 1ns/10ps
`default_nettype none

module pin_board_model (
    input wire logic [7:0] target,
    input wire logic [3:0] skewNs,
    output logic [7:0] pins
);
    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    // pins idle high and are always driven by the board;
    // levels follow the request after a board skew, off the clock edge,
    // and a low level stays as long as it is requested
    initial begin
        pins = 8'hFF;
        forever begin
            @(target);
            pins <= #({1'b0, skewNs} + 5'h01) target;
        end
    end
endmodule
`default_nettype wire

// ### external_pin_interrupt_unit_tb_top.sv
// self-checking bench for the external pin interrupt unit
`timescale 1ns/10ps
`default_nettype none

module external_pin_interrupt_unit_tb_top;
    import pin_irq_pkg::*;

    logic mclk, rst, globalEnable, sleepActive, vectorAck, regWr, regRd;
    logic [2:0] ackIndex, vectorIndex;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData;
    logic [7:0] target, pins, requestVector;
    logic [3:0] skewNs;
    logic irq, wakeRequest;
    logic rdLate = 1'b0;
    int errors, checks_done;
    logic [DATA_W-1:0] expQ[$];
    string nameQ[$];

    pin_board_model i_board (.target(target), .skewNs(skewNs), .pins(pins));

    external_pin_interrupt_unit #(.ASYNC_COUNT(4)) i_dut (
        .mclk(mclk), .rst(rst), .externalRequestPins(pins),
        .globalEnable(globalEnable), .sleepActive(sleepActive),
        .vectorAck(vectorAck), .ackIndex(ackIndex), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .requestVector(requestVector),
        .vectorIndex(vectorIndex), .irq(irq), .wakeRequest(wakeRequest));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        check("pending reads", 8'(expQ.size()), 8'h00);
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // idle lowers all three strobes; wr and rd lower each other's, so no signal is set twice per edge
    task automatic idle(input int n);
        regWr <= 1'b0;
        regRd <= 1'b0;
        vectorAck <= 1'b0;
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        regWr <= 1'b1;
        regRd <= 1'b0;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] e,
                      input string n);
        regRd <= 1'b1;
        regWr <= 1'b0;
        regAddr <= a;
        expQ.push_back(e);
        nameQ.push_back(n);
        @(posedge mclk);
    endtask

    task automatic ack(input logic [2:0] i);
        vectorAck <= 1'b1;
        ackIndex <= i;
        @(posedge mclk);
    endtask

    task automatic pinTo(input int p, input logic v);
        target[p] <= v;
        skewNs <= 4'($urandom_range(15));
        idle(1);
    endtask

    // mask, change sense, clear flags, then write the given mask
    task automatic setup(input int p, input logic [1:0] code,
                         input logic [7:0] msk);
        logic [7:0] s;
        s = 8'h00;
        s[(p % 4) * 2 +: 2] = code;
        wr(MASK_OFS, 8'h00);
        wr(p < 4 ? ASYNC_SENSE_OFS : SYNC_SENSE_OFS, s);
        wr(FLAGS_OFS, 8'hFF);
        wr(MASK_OFS, msk);
        idle(1);
    endtask

    task automatic waitIrq(input logic lvl);
        int n;
        n = 0;
        while (irq !== lvl && n < 12) begin
            @(posedge mclk);
            n++;
        end
        if (irq !== lvl) begin
            check("irq wait", {7'h00, irq}, {7'h00, lvl});
            print_verdict();
        end
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rdLate) begin
            check(nameQ.pop_front(), regRdData, expQ.pop_front());
        end
        rdLate <= regRd;
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] rnd, e;
        int p;
        rst = 1'b1;
        globalEnable = 1'b0;
        sleepActive = 1'b0;
        vectorAck = 1'b0;
        ackIndex = 3'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 3'h0;
        regWrData = 8'h00;
        target = 8'hFF;
        skewNs = 4'h0;
        errors = 0;
        checks_done = 0;
        void'($urandom(32'hF7046464));
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        idle(4);
        rd(ASYNC_SENSE_OFS, ASYNC_SENSE_RST, "async sense");
        rd(SYNC_SENSE_OFS, SYNC_SENSE_RST, "sync sense");
        rd(MASK_OFS, MASK_RST, "mask");
        rd(FLAGS_OFS, FLAGS_RST, "flags");
        rnd = 8'($urandom());
        wr(MASK_OFS, rnd);
        wr(3'h5, 8'hFF);
        wr(PIN_STATE_OFS, 8'h00);
        rd(MASK_OFS, rnd, "mask rw");
        rd(3'h5, UNMAPPED_READ, "unmapped");
        rd(PIN_STATE_OFS, 8'hFF, "pin state");
        idle(2);
        $display("test registers done");
        for (int i = 0; i < 2; i++) begin
            for (int c = 1; c < 4; c++) begin
                p = (i == 0) ? 0 : 7;
                setup(p, 2'(c), 8'h00);
                pinTo(p, 1'b0);
                idle(7);
                e = 8'h00;
                e[p] = (c != 3);
                rd(FLAGS_OFS, e, "flag after fall");
                wr(FLAGS_OFS, 8'hFF);
                pinTo(p, 1'b1);
                idle(7);
                e[p] = (c != 2);
                rd(FLAGS_OFS, e, "flag after rise");
            end
        end
        $display("test edge modes done");
        setup(4, SENSE_CHANGE, 8'h00);
        target[4] <= 1'b0;
        idle(2);
        target[4] <= 1'b1;
        idle(8);
        rd(FLAGS_OFS, 8'h10, "two cycle pulse");
        idle(1);
        $display("test short pulse done");
        globalEnable <= 1'b1;
        setup(7, SENSE_RISE, 8'h80);
        pinTo(7, 1'b0);
        idle(8);
        check("fall in rise mode", {7'h00, irq}, 8'h00);
        pinTo(7, 1'b1);
        waitIrq(1'b1);
        check("vector", {5'h00, vectorIndex}, 8'h07);
        check("request", requestVector, 8'h80);
        wr(FLAGS_OFS, 8'h7F);
        idle(2);
        check("zero written", {7'h00, irq}, 8'h01);
        ack(3'h7);
        idle(2);
        check("ack clear", {7'h00, irq}, 8'h00);
        globalEnable <= 1'b0;
        pinTo(7, 1'b0);
        idle(4);
        pinTo(7, 1'b1);
        idle(8);
        check("no global", {7'h00, irq}, 8'h00);
        rd(FLAGS_OFS, 8'h80, "flag unmasked");
        globalEnable <= 1'b1;
        idle(2);
        check("global on", requestVector, 8'h80);
        wr(FLAGS_OFS, 8'h80);
        idle(2);
        check("one written", {7'h00, irq}, 8'h00);
        $display("test vector done");
        globalEnable <= 1'b0;
        setup(6, SENSE_LOW, 8'h40);
        pinTo(6, 1'b0);
        idle(6);
        check("wake level", {7'h00, wakeRequest}, 8'h01);
        check("level no global", {7'h00, irq}, 8'h00);
        globalEnable <= 1'b1;
        idle(40);
        check("level held", {7'h00, irq}, 8'h01);
        rd(FLAGS_OFS, 8'h00, "level flag");
        pinTo(6, 1'b1);
        idle(6);
        check("level gone", {7'h00, irq}, 8'h00);
        $display("test level done");
        // masked async inputs lose their buffers while asleep
        setup(2, SENSE_CHANGE, 8'h01);
        sleepActive <= 1'b1;
        idle(4);
        rd(PIN_STATE_OFS, 8'hF1, "gated pins");
        sleepActive <= 1'b0;
        idle(5);
        rd(FLAGS_OFS, 8'h04, "sleep flags");
        wr(MASK_OFS, 8'h04);
        idle(2);
        check("async wake", {7'h00, wakeRequest}, 8'h01);
        check("vector two", {5'h00, vectorIndex}, 8'h02);
        $display("test sleep done");
        print_verdict();
    end
endmodule
`default_nettype wire
